//--- src/dsrx_top.sv
// Function
// [RULE_01] Bits pair into dibits; the earlier bit is the left one.
// [RULE_02] DQPSK phase change 0,+90,+180,-90 gives 00,01,11,10.
// [RULE_03] Positive shift is counterclockwise; polarity bit 7 or 6 reverses it.
// [RULE_04] DBPSK bits come from plain differential decoding.
// [RULE_05] Descrambler is self-synchronising on a 7-bit register, no seed.
// [RULE_06] Input is exclusive-ored with exactly two register taps.
// [RULE_07] Register holds received bits; output is input xor tap sum.
// [RULE_08] CCK timing, phase tracking and rate come from low-rate section.
// [RULE_09] Phase on last header bit becomes the high-rate reference.
// [RULE_10] Derotation removes carrier offset; stream decimated to 11 MSPS.
// [RULE_11] Top rate: six index bits of 64 plus two phase bits.
// [RULE_12] At 5.5 Mbps four outputs watched; two index plus two phase bits.
// [RULE_13] Equalizer corrects Walsh outputs for inter-chip leakage before picking.
// [RULE_14] Residual of each decided symbol is removed from the next one.
// [RULE_15] Equalizer trained once per packet, then held fixed.
// [RULE_16] Receive config bits 4 and 5 disable the two equalizer parts.
// [RULE_17] Costas error on derotated chips, only at transitions, drives NCO.
// [RULE_18] Timing interpolator steps of 1/8 chip, limited to 72 steps.
// [RULE_19] Transmitter SERVICE bit 2 tells whether its clocks share a crystal.
// [RULE_20] With service bit 2 set, bit timing counts down carrier offset.
// [RULE_21] Locked-oscillator config bit 6 enables the slaved tracking.
// [RULE_22] After acquisition, seven symbols fill the descrambler before data valid.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module dsrx_top
  import dsrx_pkg::*;
#(
  parameter int SW = 8,
  parameter int CW = 12
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] rate_sel,
  input wire logic acq_done,
  input wire logic header_last,
  input wire logic pkt_end,
  input wire logic svc_tx_locked,
  input wire logic smp_valid,
  input wire logic signed [SW-1:0] smp_i,
  input wire logic signed [SW-1:0] smp_q,
  input wire logic psk_valid,
  input wire logic [1:0] psk_phase,
  input wire logic corr_valid,
  input wire logic corr_first,
  input wire logic corr_last,
  input wire logic signed [CW-1:0] corr_i,
  input wire logic signed [CW-1:0] corr_q,
  input wire logic train_valid,
  input wire logic signed [7:0] train_ici,
  input wire logic signed [7:0] train_isi,
  input wire logic chip_early,
  input wire logic chip_late,
  output logic derot_valid,
  output logic signed [SW-1:0] derot_i,
  output logic signed [SW-1:0] derot_q,
  output logic signed [7:0] timing_steps,
  output logic rx_valid,
  output logic rx_data
);
  dsrx_state_t st_r;
  dsrx_rate_t rate_r;
  logic [7:0] pol_r, svc_r, rxc_r, lo_r;
  logic [2:0] fill_r;
  logic rev, ici_on, isi_on, lock_trk;
  logic [1:0] ref_r;
  logic trained_r;
  logic signed [7:0] ici_r, isi_r;
  logic [7:0] sh_r;
  logic [3:0] cnt_r;
  logic sym_ld;
  logic [7:0] sym_bits;
  logic [3:0] sym_cnt;
  logic dsc_valid, dsc_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.
  function automatic logic [1:0] dibit_of(input logic [1:0] d);
    unique case (d)
      2'h0: dibit_of = 2'b00;
      2'h1: dibit_of = 2'b01; // [RULE_02]
      2'h2: dibit_of = 2'b11;
      2'h3: dibit_of = 2'b10;
    endcase
  endfunction

  function automatic logic [1:0] phase_diff(input logic [1:0] now, input logic [1:0] prv,
                                            input logic rv);
    logic [1:0] d;
    d = now - prv;
    phase_diff = rv ? 2'(-d) : d; // [RULE_03]
  endfunction

  function automatic logic [CW:0] mag(input logic signed [CW-1:0] a,
                                      input logic signed [CW-1:0] b);
    logic [CW-1:0] x, y;
    x = a[CW-1] ? CW'(-a) : a;
    y = b[CW-1] ? CW'(-b) : b;
    mag = {1'b0, x} + {1'b0, y};
  endfunction

  function automatic logic signed [CW-1:0] scale(input logic signed [CW-1:0] v,
                                                 input logic signed [7:0] c);
    logic signed [CW+7:0] p;
    p = v * c;
    scale = p[CW-1+EQ_SHIFT:EQ_SHIFT];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB slave; zero wait states, read data captured in the setup cycle.
  assign rev = pol_r[POL_REV_A] | pol_r[POL_REV_B];
  assign ici_on = ~rxc_r[RXC_ICI_OFF]; // [RULE_16]
  assign isi_on = ~rxc_r[RXC_ISI_OFF]; // [RULE_16]
  assign lock_trk = svc_r[SVC_LOCK] & lo_r[LO_EN] & svc_tx_locked; // [RULE_19] [RULE_20] [RULE_21]
  assign pready = 1'b1;

  function automatic logic addr_ok(input logic [9:0] a);
    addr_ok = (a == ADDR_POL) || (a == ADDR_SVC) || (a == ADDR_RXC) ||
              (a == ADDR_LO) || (a == ADDR_STAT);
  endfunction

  assign pslverr = psel & penable & ~addr_ok(paddr);

  always_ff @(posedge clk) begin
    if (srst) begin
      pol_r <= RST_POL;
      svc_r <= RST_SVC;
      rxc_r <= RST_RXC;
      lo_r <= RST_LO;
    end else if (ce && psel && penable && pwrite) begin
      unique case (paddr)
        ADDR_POL: pol_r <= pwdata[7:0];
        ADDR_SVC: svc_r <= pwdata[7:0];
        ADDR_RXC: rxc_r <= pwdata[7:0];
        ADDR_LO: lo_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prdata <= 32'h0;
    end else if (ce && psel && !penable) begin
      unique case (paddr)
        ADDR_POL: prdata <= {24'h0, pol_r};
        ADDR_SVC: prdata <= {24'h0, svc_r};
        ADDR_RXC: prdata <= {24'h0, rxc_r};
        ADDR_LO: prdata <= {24'h0, lo_r};
        ADDR_STAT: prdata <= {16'h0, timing_steps, 2'h0, lock_trk, trained_r,
                              1'b0, st_r};
        default: prdata <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Packet state: rate and timing handed over by the low-rate section.
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= DSRX_IDLE;
      fill_r <= 3'h0;
      rate_r <= DSRX_DBPSK;
    end else if (ce) begin
      if (pkt_end) begin
        st_r <= DSRX_IDLE;
      end else begin
        unique case (st_r)
          DSRX_IDLE: begin
            if (acq_done) begin
              st_r <= DSRX_FILL;
              fill_r <= 3'h0;
            end
          end
          DSRX_FILL: begin
            if (sym_ld) begin
              fill_r <= fill_r + 3'h1;
              // RUN starts with the load of the eighth symbol, so seven stay hidden.
              if (fill_r == FILL_SYMS) begin
                st_r <= DSRX_RUN; // [RULE_22]
              end
            end
          end
          DSRX_RUN: ;
        endcase
      end
      if (header_last) begin
        rate_r <= dsrx_rate_t'(rate_sel); // [RULE_08]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Derotation, 11 MSPS decimation and Costas carrier loop.
  logic [15:0] nco_ph_r;
  logic signed [15:0] nco_fr_r;
  logic dec_r, prev_sgn_r;
  logic signed [SW-1:0] ri, rq;
  logic signed [SW:0] cerr;
  logic trk_on;

  assign trk_on = ~st_r[0];

  always_comb begin
    unique case (nco_ph_r[15:14])
      2'h0: begin ri = smp_i; rq = smp_q; end
      2'h1: begin ri = smp_q; rq = SW'(-smp_i); end
      2'h2: begin ri = SW'(-smp_i); rq = SW'(-smp_q); end
      2'h3: begin ri = SW'(-smp_q); rq = smp_i; end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dec_r <= 1'b0;
      derot_valid <= 1'b0;
      derot_i <= '0;
      derot_q <= '0;
    end else if (ce) begin
      derot_valid <= 1'b0;
      if (smp_valid) begin
        dec_r <= ~dec_r;
        if (!dec_r) begin
          derot_valid <= 1'b1; // [RULE_10]
          derot_i <= ri; // [RULE_10]
          derot_q <= rq;
        end
      end
    end
  end

  always_comb begin
    cerr = (derot_i[SW-1] ? -(SW+1)'(derot_q) : (SW+1)'(derot_q)) -
           (derot_q[SW-1] ? -(SW+1)'(derot_i) : (SW+1)'(derot_i));
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      nco_ph_r <= 16'h0;
      nco_fr_r <= 16'sh0;
      prev_sgn_r <= 1'b0;
    end else if (ce) begin
      if (!trk_on) begin
        nco_fr_r <= 16'sh0;
      end else if (derot_valid) begin
        prev_sgn_r <= derot_i[SW-1];
        nco_ph_r <= nco_ph_r + 16'(nco_fr_r);
        if (prev_sgn_r != derot_i[SW-1]) begin
          nco_fr_r <= nco_fr_r + (16'(cerr) <<< LOOP_KI_SH); // [RULE_17]
          nco_ph_r <= nco_ph_r + 16'(nco_fr_r) + (16'(cerr) <<< LOOP_KP_SH); // [RULE_17]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Symbol timing: early/late steps, or slaved to the carrier offset.
  logic [15:0] lo_acc_r;
  logic [16:0] lo_sum;
  logic step_up, step_dn;

  assign lo_sum = {1'b0, lo_acc_r} +
                  {1'b0, (nco_fr_r[15] ? 16'(-nco_fr_r) : 16'(nco_fr_r))};
  always_comb begin
    if (lock_trk) begin
      step_up = derot_valid & lo_sum[16] & ~nco_fr_r[15]; // [RULE_20]
      step_dn = derot_valid & lo_sum[16] & nco_fr_r[15];
    end else begin
      step_up = chip_late & ~chip_early;
      step_dn = chip_early & ~chip_late;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lo_acc_r <= 16'h0;
      timing_steps <= 8'sh0;
    end else if (ce) begin
      if (!trk_on) begin
        lo_acc_r <= 16'h0;
        timing_steps <= 8'sh0;
      end else begin
        if (derot_valid) begin
          lo_acc_r <= lo_sum[15:0];
        end
        if (step_up && timing_steps < TSTEP_MAX) begin
          timing_steps <= timing_steps + 8'sd1; // [RULE_18]
        end else if (step_dn && timing_steps > -TSTEP_MAX) begin
          timing_steps <= timing_steps - 8'sd1; // [RULE_18]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Equalizer training and CCK picker with decision feedback.
  logic [5:0] idx_r, best_idx_r;
  logic [CW:0] best_mag_r;
  logic signed [CW-1:0] best_i_r, best_q_r, pv_i_r, pv_q_r;
  logic signed [CW-1:0] res_i_r, res_q_r, ci, cq;
  logic is_cck, watch, better;
  logic [5:0] cur_idx, win_idx;
  logic signed [CW-1:0] win_i, win_q;
  logic [1:0] win_quad;

  assign is_cck = rate_r[1];
  assign cur_idx = corr_first ? 6'h0 : idx_r;
  assign watch = (rate_r == DSRX_CCK11) || (cur_idx < CCK55_WATCH); // [RULE_11] [RULE_12]

  always_comb begin
    ci = corr_i;
    cq = corr_q;
    if (ici_on && !corr_first) begin
      ci = ci - scale(pv_i_r, ici_r); // [RULE_13]
      cq = cq - scale(pv_q_r, ici_r);
    end
    if (isi_on && corr_first) begin
      ci = ci - res_i_r; // [RULE_14]
      cq = cq - res_q_r;
    end
    better = watch && (corr_first || mag(ci, cq) > best_mag_r);
    win_idx = better ? cur_idx : best_idx_r;
    win_i = better ? ci : best_i_r;
    win_q = better ? cq : best_q_r;
    win_quad = {win_q[CW-1], win_i[CW-1] ^ win_q[CW-1]}; // [RULE_11] [RULE_12]
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      trained_r <= 1'b0;
      ici_r <= 8'sh0;
      isi_r <= 8'sh0;
    end else if (ce) begin
      if (pkt_end) begin
        trained_r <= 1'b0;
      end else if (train_valid && !trained_r) begin
        trained_r <= 1'b1; // [RULE_15]
        ici_r <= train_ici;
        isi_r <= train_isi;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      idx_r <= 6'h0;
      best_idx_r <= 6'h0;
      best_mag_r <= '0;
      best_i_r <= '0;
      best_q_r <= '0;
      pv_i_r <= '0;
      pv_q_r <= '0;
      res_i_r <= '0;
      res_q_r <= '0;
    end else if (ce) begin
      if (!trk_on) begin
        res_i_r <= '0;
        res_q_r <= '0;
      end else if (corr_valid && is_cck) begin
        idx_r <= cur_idx + 6'h1;
        pv_i_r <= corr_i;
        pv_q_r <= corr_q;
        best_idx_r <= win_idx;
        best_i_r <= win_i;
        best_q_r <= win_q;
        best_mag_r <= mag(win_i, win_q);
        if (corr_last) begin
          res_i_r <= scale(win_i, isi_r); // [RULE_14]
          res_q_r <= scale(win_q, isi_r);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Differential decoding into a left-aligned symbol word.
  logic [1:0] dph, dcck;

  always_comb begin
    dph = phase_diff(psk_phase, ref_r, rev);
    dcck = phase_diff(win_quad, ref_r, rev);
    sym_ld = 1'b0;
    sym_bits = 8'h0;
    sym_cnt = 4'h0;
    if (trk_on && !is_cck && psk_valid) begin
      sym_ld = 1'b1;
      if (rate_r == DSRX_DBPSK) begin
        sym_bits = {dph[1], 7'h0}; // [RULE_04]
        sym_cnt = 4'h1;
      end else begin
        sym_bits = {dibit_of(dph), 6'h0}; // [RULE_01] [RULE_02]
        sym_cnt = 4'h2;
      end
    end else if (trk_on && is_cck && corr_valid && corr_last) begin
      sym_ld = 1'b1;
      if (rate_r == DSRX_CCK11) begin
        sym_bits = {dibit_of(dcck), win_idx}; // [RULE_11]
        sym_cnt = 4'h8;
      end else begin
        sym_bits = {dibit_of(dcck), win_idx[1:0], 4'h0}; // [RULE_12]
        sym_cnt = 4'h4;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ref_r <= 2'h0;
    end else if (ce) begin
      if (header_last && psk_valid) begin
        ref_r <= psk_phase; // [RULE_09]
      end else if (sym_ld) begin
        ref_r <= is_cck ? win_quad : psk_phase;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serializer, first bit in time leaves first, then the descrambler.
  always_ff @(posedge clk) begin
    if (srst) begin
      sh_r <= 8'h0;
      cnt_r <= 4'h0;
    end else if (ce) begin
      if (sym_ld) begin
        sh_r <= sym_bits;
        cnt_r <= sym_cnt;
      end else if (cnt_r != 4'h0) begin
        sh_r <= {sh_r[6:0], 1'b0}; // [RULE_01]
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end

  dsrx_descram u_descram (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .clr(acq_done),
    .in_valid(cnt_r != 4'h0),
    .in_bit(sh_r[7]),
    .out_valid(dsc_valid),
    .out_bit(dsc_bit)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_valid <= 1'b0;
      rx_data <= 1'b0;
    end else if (ce) begin
      rx_valid <= dsc_valid & st_r[2]; // [RULE_22]
      rx_data <= dsc_bit;
    end
  end
endmodule
`default_nettype wire

//--- src/dsrx_pkg.sv
package dsrx_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_POL = 8'h02;
  localparam logic [7:0] IDX_SVC = 8'h0c;
  localparam logic [7:0] IDX_RXC = 8'h14;
  localparam logic [7:0] IDX_LO = 8'h42;
  localparam logic [7:0] IDX_STAT = 8'h7f;
  localparam logic [9:0] ADDR_POL = {IDX_POL, 2'b00};
  localparam logic [9:0] ADDR_SVC = {IDX_SVC, 2'b00};
  localparam logic [9:0] ADDR_RXC = {IDX_RXC, 2'b00};
  localparam logic [9:0] ADDR_LO = {IDX_LO, 2'b00};
  localparam logic [9:0] ADDR_STAT = {IDX_STAT, 2'b00};
  localparam logic [7:0] RST_POL = 8'h00;
  localparam logic [7:0] RST_SVC = 8'h04;
  localparam logic [7:0] RST_RXC = 8'hc8;
  localparam logic [7:0] RST_LO = 8'h00;
  localparam int POL_REV_A = 7;
  localparam int POL_REV_B = 6;
  localparam int RXC_ICI_OFF = 4;
  localparam int RXC_ISI_OFF = 5;
  localparam int SVC_LOCK = 2;
  localparam int LO_EN = 6;
  localparam logic [2:0] FILL_SYMS = 3'h7;
  localparam logic signed [7:0] TSTEP_MAX = 8'sd72;
  localparam int DESCR_TAP_A = 3;
  localparam int DESCR_TAP_B = 6;
  localparam int EQ_SHIFT = 6;
  localparam int LOOP_KP_SH = 4;
  localparam int LOOP_KI_SH = 2;
  localparam logic [5:0] CCK55_WATCH = 6'h04;
  typedef enum logic [1:0] {
    DSRX_DBPSK = 2'h0,
    DSRX_DQPSK = 2'h1,
    DSRX_CCK55 = 2'h2,
    DSRX_CCK11 = 2'h3
  } dsrx_rate_t;
  typedef enum logic [2:0] {
    DSRX_IDLE = 3'b001,
    DSRX_FILL = 3'b010,
    DSRX_RUN = 3'b100
  } dsrx_state_t;
endpackage

//--- src/dsrx_descram.sv
`timescale 1ns/1ps
`default_nettype none
module dsrx_descram
  import dsrx_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic clr,
  input wire logic in_valid,
  input wire logic in_bit,
  output logic out_valid,
  output logic out_bit
);
  logic [6:0] sr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Self-synchronising multiplier: the register holds received bits, no seed.
  always_ff @(posedge clk) begin
    if (srst || (ce && clr)) begin
      sr_r <= 7'h00;
    end else if (ce && in_valid) begin
      sr_r <= {sr_r[5:0], in_bit}; // [RULE_05] [RULE_07]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      out_bit <= 1'b0;
      out_valid <= 1'b0;
    end else if (ce) begin
      out_valid <= in_valid;
      if (in_valid) begin
        out_bit <= in_bit ^ sr_r[DESCR_TAP_A] ^ sr_r[DESCR_TAP_B]; // [RULE_06] [RULE_07]
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/dsrx_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dsrx_top_properties
  import dsrx_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic acq_done,
  input wire logic pkt_end,
  input wire logic smp_valid,
  input wire logic chip_early,
  input wire logic chip_late,
  input wire logic derot_valid,
  input wire logic signed [7:0] timing_steps,
  input wire logic rx_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_steps_bound: assert property (timing_steps <= TSTEP_MAX &&
    timing_steps >= -TSTEP_MAX)
    else $error("timing steps out of range");
  a_step_size: assert property ($changed(timing_steps) && timing_steps != 0 |->
    timing_steps == $past(timing_steps) + 8'sd1 || timing_steps == $past(timing_steps) - 8'sd1)
    else $error("timing step larger than one eighth chip");
  a_step_cause: assert property ($changed(timing_steps) |-> derot_valid ||
    $past(chip_early || chip_late || derot_valid || acq_done) || $past(pkt_end, 2))
    else $error("timing moved without a cause");
  a_idle_zero: assert property (pkt_end && ce ##1 ce |=> timing_steps == 0)
    else $error("timing not cleared at packet end");
  a_decim_cause: assert property (derot_valid |-> $past(smp_valid))
    else $error("derotated sample without input sample");
  a_decim_gap: assert property (derot_valid |=> !derot_valid)
    else $error("derotated stream not decimated");
  a_fill_quiet: assert property (acq_done && ce |=> !rx_valid [*8])
    else $error("data valid during descrambler fill");
  a_reset_quiet: assert property (disable iff (1'b0)
    srst |=> !rx_valid && !derot_valid && timing_steps == 0)
    else $error("outputs active after reset");
  c_rx: cover property (rx_valid);
  c_max: cover property (timing_steps == TSTEP_MAX);
  c_derot: cover property (derot_valid);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind dsrx_top dsrx_top_properties u_props (.clk(clk), .srst(srst), .ce(ce),
  .acq_done(acq_done), .pkt_end(pkt_end), .smp_valid(smp_valid), .chip_early(chip_early),
  .chip_late(chip_late), .derot_valid(derot_valid), .timing_steps(timing_steps),
  .rx_valid(rx_valid));
`default_nettype wire

//--- bench/dsrx_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsrx_mac_model (
  input wire logic clk,
  input wire logic clr,
  input wire logic rx_valid,
  input wire logic rx_data,
  output logic [7:0] cnt,
  output logic [31:0] bits
);
  // Collects the received stream with the newest bit at the bottom.
  always_ff @(posedge clk) begin
    if (clr) begin
      cnt <= 8'h00;
      bits <= 32'h0;
    end else if (rx_valid) begin
      cnt <= cnt + 8'h01;
      bits <= {bits[30:0], rx_data};
    end
  end
endmodule
`default_nettype wire

//--- bench/dsrx_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dsrx_top_bench
  import dsrx_pkg::*;
;
  logic clk, srst, ce, psel, penable, pwrite, pready, pslverr, rerr;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rdat, mbits;
  logic [1:0] rate_sel, psk_phase;
  logic acq_done, header_last, pkt_end, svc_tx_locked, smp_valid, psk_valid;
  logic corr_valid, corr_first, corr_last, train_valid, chip_early, chip_late;
  logic signed [7:0] smp_i, smp_q, train_ici, train_isi, derot_i, derot_q, timing_steps;
  logic signed [11:0] corr_i, corr_q;
  logic derot_valid, rx_valid, rx_data;
  logic [7:0] mcnt;
  int fails = 0;
  int compares = 0;
  int dcnt = 0;

  dsrx_top dut_u (.clk(clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rate_sel(rate_sel), .acq_done(acq_done), .header_last(header_last),
    .pkt_end(pkt_end), .svc_tx_locked(svc_tx_locked), .smp_valid(smp_valid), .smp_i(smp_i),
    .smp_q(smp_q), .psk_valid(psk_valid), .psk_phase(psk_phase), .corr_valid(corr_valid),
    .corr_first(corr_first), .corr_last(corr_last), .corr_i(corr_i), .corr_q(corr_q),
    .train_valid(train_valid), .train_ici(train_ici), .train_isi(train_isi),
    .chip_early(chip_early), .chip_late(chip_late), .derot_valid(derot_valid),
    .derot_i(derot_i), .derot_q(derot_q), .timing_steps(timing_steps),
    .rx_valid(rx_valid), .rx_data(rx_data));
  // The receiver side restarts its capture at every acquisition.
  dsrx_mac_model mac_u (.clk(clk), .clr(acq_done), .rx_valid(rx_valid), .rx_data(rx_data),
    .cnt(mcnt), .bits(mbits));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (derot_valid === 1'b1) dcnt++;

  task automatic stop_test();
    $display("Counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic x);
    apb(1'b0, a, 32'h0);
    chk(rdat, e, "read data");
    chk({31'h0, rerr}, {31'h0, x}, "slave error");
  endtask
  task automatic chips(input logic [1:0] v, input int k);
    repeat (k) begin
      @(posedge clk) {chip_early, chip_late} <= v;
      @(posedge clk) {chip_early, chip_late} <= 2'b00;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(ADDR_POL, {24'h0, RST_POL}, 1'b0);
    rd(ADDR_SVC, {24'h0, RST_SVC}, 1'b0);
    rd(ADDR_RXC, {24'h0, RST_RXC}, 1'b0);
    rd(ADDR_LO, {24'h0, RST_LO}, 1'b0);
    rd(ADDR_STAT, 32'h1, 1'b0);
    apb(1'b1, 10'h004, 32'hff);
    rd(10'h004, 32'h0, 1'b1);
    apb(1'b1, ADDR_RXC, 32'h30);
    rd(ADDR_RXC, 32'h30, 1'b0);
    apb(1'b1, ADDR_LO, 32'h40);
    rd(ADDR_LO, 32'h40, 1'b0);
    apb(1'b1, ADDR_LO, 32'h0);
    apb(1'b1, ADDR_RXC, {24'h0, RST_RXC});
    $display("test regs done");
  endtask
  task automatic t_psk(input logic [1:0] rate, input logic [7:0] pol);
    logic [1:0] ch[12] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h1, 2'h3, 2'h2, 2'h0, 2'h2, 2'h1, 2'h3};
    logic [1:0] ph = 2'h0;
    logic [1:0] c;
    logic [6:0] h = 7'h0;
    logic [31:0] ex = 32'h0;
    logic e;
    int nb;
    nb = (rate == DSRX_DQPSK) ? 2 : 1;
    apb(1'b1, ADDR_POL, {24'h0, pol});
    pkt_end <= 1'b1;
    @(posedge clk);
    {pkt_end, header_last, psk_valid, psk_phase, rate_sel, train_valid} <= {3'b011, 2'h0, rate, 1'b1};
    @(posedge clk);
    {header_last, psk_valid, train_valid, acq_done} <= 4'b0001;
    @(posedge clk);
    acq_done <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      c = (nb == 2) ? ch[i] : {ch[i][1], 1'b0};
      ph = ph + c;
      tick(9);
      {psk_valid, psk_phase} <= {1'b1, ph};
      @(posedge clk);
      psk_valid <= 1'b0;
      if (pol[7] | pol[6]) c = -c;
      for (int j = nb - 1; j >= 0; j--) begin
        e = (nb == 2 && j == 0) ? c[1] ^ c[0] : c[1];
        if (i >= FILL_SYMS) ex = {ex[30:0], e ^ h[3] ^ h[6]};
        h = {h[5:0], e};
      end
    end
    tick(10);
    chk(32'(mcnt), 32'((12 - FILL_SYMS) * nb), "bit count");
    chk(mbits, ex, "bit stream");
    $display("test psk done");
  endtask
  task automatic t_cck();
    logic [1:0] q[9] = '{2'h1, 2'h3, 2'h0, 2'h2, 2'h2, 2'h1, 2'h3, 2'h0, 2'h1};
    logic [1:0] r = 2'h0;
    logic [1:0] d;
    logic [3:0] b;
    logic [6:0] h = 7'h0;
    logic [31:0] ex = 32'h0;
    apb(1'b1, ADDR_POL, 32'h0);
    apb(1'b1, ADDR_RXC, 32'h30);
    @(posedge clk) pkt_end <= 1'b1;
    @(posedge clk) {pkt_end, header_last, psk_valid, psk_phase, rate_sel} <= {3'b011, 2'h0, DSRX_CCK55};
    @(posedge clk) {header_last, psk_valid, acq_done} <= 3'b001;
    @(posedge clk) acq_done <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      for (int k = 0; k < 4; k++) begin
        @(posedge clk);
        {corr_valid, corr_first, corr_last} <= {1'b1, k == 0, k == 3};
        corr_i <= (k != i % 4) ? 12'sh0 : (q[i][0] ^ q[i][1]) ? -12'sd100 : 12'sd100;
        corr_q <= (k != i % 4) ? 12'sh0 : q[i][1] ? -12'sd100 : 12'sd100;
      end
      @(posedge clk) corr_valid <= 1'b0;
      tick(5);
      d = q[i] - r;
      r = q[i];
      b = {d[1], d[1] ^ d[0], 2'(i % 4)};
      for (int j = 3; j >= 0; j--) begin
        if (i >= FILL_SYMS) ex = {ex[30:0], b[j] ^ h[3] ^ h[6]};
        h = {h[5:0], b[j]};
      end
    end
    tick(5);
    chk(32'(mcnt), 32'((9 - FILL_SYMS) * 4), "cck bit count");
    chk(mbits, ex, "cck bit stream");
    apb(1'b1, ADDR_RXC, {24'h0, RST_RXC});
    $display("test cck done");
  endtask
  task automatic t_derot();
    int d0;
    d0 = dcnt;
    @(posedge clk);
    {smp_valid, smp_i, smp_q} <= {1'b1, 8'sd20, -8'sd9};
    tick(6);
    smp_valid <= 1'b0;
    tick(4);
    chk(32'(dcnt - d0), 32'h3, "derotated count");
    chk({16'h0, derot_i, derot_q}, 32'h000014f7, "derotated sample");
    $display("test derot done");
  endtask
  task automatic t_timing();
    svc_tx_locked <= 1'b1;
    chips(2'b01, 80);
    tick(2);
    chk(32'(timing_steps), 32'(TSTEP_MAX), "steps at limit");
    chips(2'b10, 3);
    chips(2'b11, 1);
    @(posedge clk) ce <= 1'b0;
    chips(2'b10, 2);
    @(posedge clk) ce <= 1'b1;
    tick(2);
    chk(32'(timing_steps), 32'(TSTEP_MAX - 8'sd3), "steps back");
    @(posedge clk) pkt_end <= 1'b1;
    @(posedge clk) pkt_end <= 1'b0;
    tick(2);
    chk(32'(timing_steps), 32'h0, "steps idle");
    svc_tx_locked <= 1'b0;
    $display("test timing done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {srst, ce} = 2'b11;
    {psel, penable, pwrite, acq_done, header_last, pkt_end, svc_tx_locked} = '0;
    {smp_valid, psk_valid, corr_valid, corr_first, corr_last, train_valid} = '0;
    {chip_early, chip_late, paddr, pwdata, rate_sel, psk_phase, smp_i, smp_q} = '0;
    {train_ici, train_isi, corr_i, corr_q} = {8'sd16, 8'sd8, 24'h0};
    tick(20);
    srst <= 1'b0;
    t_regs();
    t_psk(DSRX_DQPSK, 8'h00);
    t_psk(DSRX_DBPSK, 8'h00);
    t_psk(DSRX_DQPSK, 8'h80);
    t_psk(DSRX_DQPSK, 8'h40);
    t_cck();
    t_derot();
    t_timing();
    stop_test();
  end
  initial begin
    #50000;
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule
`default_nettype wire
